//--- src/gpio_pkg.sv
package gpio_pkg;

    localparam int NUM_PINS = 8;
    localparam int ADDR_W   = 3;
    localparam int DATA_W   = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_LATCH   = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_DIR     = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_OPTION  = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_SENSE   = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_PENDING = 3'h4;

    // Values after reset
    localparam logic [DATA_W-1:0] LATCH_RST  = 8'hff;
    localparam logic [DATA_W-1:0] DIR_RST    = 8'h00;
    localparam logic [DATA_W-1:0] OPTION_RST = 8'h40;
    localparam logic [DATA_W-1:0] SENSE_RST  = 8'h00;

    // Edge sense field, two bits per vector
    localparam int SENSE_W = 2;
    localparam logic [SENSE_W-1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [SENSE_W-1:0] SENSE_RISE     = 2'h1;
    localparam logic [SENSE_W-1:0] SENSE_FALL     = 2'h2;
    localparam logic [SENSE_W-1:0] SENSE_BOTH     = 2'h3;

    // Input filter depth and settle time in clock cycles
    localparam int SYNC_STAGES = 3;
    localparam int SYNC_SETTLE = 4;

endpackage

//--- src/gpio_port_with_ext_irq.sv
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Eight pins, each independently input or output
// - Register bit x controls pin x
// - Input mode: latch read returns pin level
// - Input-mode latch write never drives pin
// - Option bit selects floating or pull-up input
// - Option bit on input enables pin interrupt
// - Edge sense programmable per interrupt vector
// - Pins on one vector ANDed before detection
// - Vector fetch clears pending request
// - Sense change clears that vector's pending
// - Disabled pin feeds logic one to detector
// - Output mode drives latch, reads latch
// - Option selects push-pull or open-drain output
// - Peripheral output overrides direction and latch
// - Input with peripheral output reads peripheral
// - Output pin feeds latch value to peripheral
// - Request passes only when globally unmasked
// - Low-power modes keep state; irq wakes
module gpio_port_with_ext_irq
    import gpio_pkg::*;
#(
    parameter int NUM_VEC = 2
)(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // Register port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    // Pads
    input  wire logic [NUM_PINS-1:0] pin_in,
    output logic      [NUM_PINS-1:0] pin_out,
    output logic      [NUM_PINS-1:0] pin_oe,
    output logic      [NUM_PINS-1:0] pin_pull_en,
    // Peripheral alternate functions
    input  wire logic [NUM_PINS-1:0] af_out_en,
    input  wire logic [NUM_PINS-1:0] af_out_val,
    output logic      [NUM_PINS-1:0] af_in,
    // CPU interrupt side
    input  wire logic                int_mask,
    input  wire logic [NUM_VEC-1:0]  vec_fetch,
    output logic      [NUM_VEC-1:0]  irq_req,
    output logic                     wake_req
);

    localparam int PINS_PER_VEC = NUM_PINS / NUM_VEC;

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [DATA_W-1:0]   latch_r;
    logic [DATA_W-1:0]   dir_r;
    logic [DATA_W-1:0]   option_r;
    logic [DATA_W-1:0]   sense_r;
    logic [NUM_VEC-1:0]  pend_r;
    logic [NUM_VEC-1:0]  vec_set;
    logic [NUM_VEC-1:0]  sense_chg;
    logic [NUM_VEC-1:0]  vec_comb;
    logic [NUM_VEC-1:0]  prev_r;
    logic [NUM_PINS-1:0] pin_lvl_r;
    logic [NUM_PINS-1:0] int_en;
    logic [NUM_PINS-1:0] eff_val;
    logic [NUM_PINS-1:0] eff_dir;
    logic [NUM_PINS-1:0] eff_pp;
    logic [NUM_PINS-1:0] read_val;
    logic [DATA_W-1:0]   rdata_nxt;

    logic wr_latch;
    logic wr_dir;
    logic wr_option;
    logic wr_sense;

    assign wr_latch  = reg_wr && (reg_addr == ADDR_LATCH);
    assign wr_dir    = reg_wr && (reg_addr == ADDR_DIR);
    assign wr_option = reg_wr && (reg_addr == ADDR_OPTION);
    assign wr_sense  = reg_wr && (reg_addr == ADDR_SENSE);

    // Latch write always stores, whatever the direction
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            latch_r <= LATCH_RST;
        else if (wr_latch)
            latch_r <= reg_wdata;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            dir_r <= DIR_RST;
        else if (wr_dir)
            dir_r <= reg_wdata;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            option_r <= OPTION_RST;
        else if (wr_option)
            option_r <= reg_wdata;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sense_r <= SENSE_RST;
        else if (wr_sense)
            sense_r <= reg_wdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin input filter

    logic [NUM_PINS-1:0] sync1_r;
    logic [NUM_PINS-1:0] sync2_r;
    logic [NUM_PINS-1:0] sync3_r;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_r <= '1;
            sync2_r <= '1;
            sync3_r <= '1;
        end
        else
        begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // A level counts only once two late stages agree
    generate
        for (genvar p = 0; p < NUM_PINS; p++)
        begin : g_pin
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    pin_lvl_r[p] <= 1'b1;
                else if (sync2_r[p] == sync3_r[p])
                    pin_lvl_r[p] <= sync3_r[p];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive and alternate functions

    always_comb
    begin
        eff_dir  = dir_r | af_out_en;
        eff_val  = (af_out_en & af_out_val) | (~af_out_en & latch_r);
        eff_pp   = option_r;
        int_en   = ~dir_r & option_r & ~af_out_en;
        read_val = (af_out_en & af_out_val)
                 | (~af_out_en & dir_r & latch_r)
                 | (~af_out_en & ~dir_r & pin_lvl_r);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_out     <= '1;
            pin_oe      <= '0;
            pin_pull_en <= '0;
            af_in       <= '1;
        end
        else
        begin
            pin_out     <= eff_val;
            // Open drain releases the pad for a one
            pin_oe      <= eff_dir & (eff_pp | ~eff_val);
            pin_pull_en <= ~eff_dir & option_r;
            // Output pins hand the latch to the peripheral, not the pad
            af_in       <= (dir_r & latch_r) | (~dir_r & pin_lvl_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External interrupt detection

    generate
        for (genvar v = 0; v < NUM_VEC; v++)
        begin : g_vec
            logic [PINS_PER_VEC-1:0] grp_lvl;
            logic [PINS_PER_VEC-1:0] grp_en;
            logic [SENSE_W-1:0]      sense;

            assign grp_lvl = pin_lvl_r[v*PINS_PER_VEC +: PINS_PER_VEC];
            assign grp_en  = int_en[v*PINS_PER_VEC +: PINS_PER_VEC];
            assign sense   = sense_r[v*SENSE_W +: SENSE_W];
            // A low enabled pin holds the group low and hides others
            assign vec_comb[v]  = &(grp_lvl | ~grp_en);
            assign sense_chg[v] = wr_sense && (reg_wdata[v*SENSE_W +: SENSE_W] != sense);

            always_comb
            begin
                unique case (sense)
                    SENSE_FALL_LOW: vec_set[v] = ~vec_comb[v];
                    SENSE_RISE:     vec_set[v] = ~prev_r[v] & vec_comb[v];
                    SENSE_FALL:     vec_set[v] = prev_r[v] & ~vec_comb[v];
                    SENSE_BOTH:     vec_set[v] = prev_r[v] ^ vec_comb[v];
                endcase
            end

            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    prev_r[v] <= 1'b1;
                else
                    prev_r[v] <= vec_comb[v];
            end

            // A new event beats a clear in the same cycle
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    pend_r[v] <= 1'b0;
                else
                    pend_r[v] <= vec_set[v] | (pend_r[v] & ~(vec_fetch[v] | sense_chg[v]));
            end
        end
    endgenerate

    // Held in halt or wait since nothing here stops the clock
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_req  <= '0;
            wake_req <= 1'b0;
        end
        else
        begin
            irq_req  <= pend_r & {NUM_VEC{~int_mask}};
            wake_req <= |pend_r && !int_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read

    always_comb
    begin
        rdata_nxt = '0;
        unique case (reg_addr)
            ADDR_LATCH:   rdata_nxt = read_val;
            ADDR_DIR:     rdata_nxt = dir_r;
            ADDR_OPTION:  rdata_nxt = option_r;
            ADDR_SENSE:   rdata_nxt = sense_r;
            ADDR_PENDING: rdata_nxt[NUM_VEC-1:0] = pend_r;
            default:      rdata_nxt = '0;
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= '0;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_input_read: assert property (
        reg_rd && reg_addr == ADDR_LATCH && dir_r == '0 && af_out_en == '0
        |=> reg_rdata == $past(pin_lvl_r))
        else $error("input read does not return pin level");

    a_output_read: assert property (
        reg_rd && reg_addr == ADDR_LATCH && &dir_r && af_out_en == '0
        |=> reg_rdata == $past(latch_r))
        else $error("output read does not return latch");

    a_af_read: assert property (
        reg_rd && reg_addr == ADDR_LATCH
        |=> (reg_rdata & $past(af_out_en)) == ($past(af_out_val) & $past(af_out_en)))
        else $error("alternate output state not read back");

    a_input_float: assert property (
        dir_r == '0 && af_out_en == '0 ##1 dir_r == '0 && af_out_en == '0
        |=> pin_oe == '0)
        else $error("input pin is driven");

    a_push_pull: assert property (
        af_out_en == '0
        |=> (~pin_oe & $past(dir_r & option_r)) == '0 && pin_out == $past(latch_r))
        else $error("push-pull drive wrong");

    a_open_drain: assert property (
        af_out_en == '0
        |=> ((pin_oe ^ ~$past(latch_r)) & $past(dir_r & ~option_r)) == '0)
        else $error("open-drain drive wrong");

    a_af_override: assert property (
        af_out_en != '0
        |=> ((pin_out ^ $past(af_out_val)) & $past(af_out_en)) == '0
            && (~(pin_oe | pin_out) & $past(af_out_en)) == '0)
        else $error("peripheral does not override pin");

    a_af_latch_in: assert property (
        &dir_r |=> af_in == $past(latch_r))
        else $error("peripheral input not fed from latch");

    a_fetch_clear: assert property (
        pend_r[0] && vec_fetch[0] && !vec_set[0] |=> !pend_r[0] ##1 !irq_req[0])
        else $error("fetch did not clear pending");

    a_sense_clear: assert property (
        sense_chg[0] && !vec_set[0] |=> !pend_r[0])
        else $error("sense change did not clear pending");

    a_irq_masked: assert property (
        int_mask ##1 int_mask |-> irq_req == '0 && !wake_req)
        else $error("request passed while masked");

    a_sync_settle: assert property (
        $stable(pin_in) [*4] |-> pin_lvl_r == pin_in)
        else $error("pin level not settled after four cycles");

    a_irq_follows: assert property (
        !int_mask && vec_set[0] ##1 !int_mask |-> pend_r[0] ##1 irq_req[0] && wake_req)
        else $error("event did not raise request");

    c_pin_event: cover property (vec_set[0] ##1 pend_r[0] ##[1:4] vec_fetch[0]);
    c_sense_clear: cover property (pend_r[1] && sense_chg[1]);
    c_af_drive: cover property (|af_out_en && reg_rd && reg_addr == ADDR_LATCH);
    c_open_drain: cover property (|(dir_r & ~option_r & ~latch_r));

endmodule // gpio_port_with_ext_irq

`default_nettype wire

//--- test/gpio_pad_model.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_pad_model
    import gpio_pkg::*;
(
    // Clock
    input  wire logic                clk,
    // Port side
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe,
    input  wire logic [NUM_PINS-1:0] pin_pull_en,
    // Board side
    input  wire logic [NUM_PINS-1:0] ext_en,
    input  wire logic [NUM_PINS-1:0] ext_val,
    output logic      [NUM_PINS-1:0] pin_level
);
    // Undriven pads wander so a stale level never passes
    logic [NUM_PINS-1:0] float_r = 8'h55;

    always_ff @(posedge clk)
        float_r <= ~float_r;

    always_comb
    begin
        for (int i = 0; i < NUM_PINS; i++)
        begin
            if (pin_oe[i])
                pin_level[i] = pin_out[i];
            else if (ext_en[i])
                pin_level[i] = ext_val[i];
            else if (pin_pull_en[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = float_r[i];
        end
    end
endmodule // gpio_pad_model

`default_nettype wire

//--- test/test_gpio_port_with_ext_irq.sv
`timescale 1ns/1ps
`default_nettype none

module test_gpio_port_with_ext_irq
    import gpio_pkg::*;
;
    logic              clk = 1'b0;
    logic              reset_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic [7:0]        pin_level, pin_out, pin_oe, pin_pull_en;
    logic [7:0]        af_out_en, af_out_val, af_in, ext_en, ext_val;
    logic              int_mask;
    logic [1:0]        vec_fetch, irq_req;
    logic              wake_req;
    int                n_errors = 0;
    int                samples_checked = 0;

    always #20 clk = ~clk;

    gpio_port_with_ext_irq dut (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_level),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .af_out_en(af_out_en),
        .af_out_val(af_out_val), .af_in(af_in), .int_mask(int_mask), .vec_fetch(vec_fetch),
        .irq_req(irq_req), .wake_req(wake_req));

    gpio_pad_model pads (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
        .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask

    task automatic fetch(input logic [1:0] v);
        @(posedge clk);
        vec_fetch <= v;
        @(posedge clk);
        vec_fetch <= 2'h0;
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Whole sequence needs well under two thousand cycles
    initial
    begin
        tick(20000);
        n_errors++;
        complete_run();
    end

    initial
    begin
        reset_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        af_out_en = 8'h00;
        af_out_val = 8'h00;
        int_mask = 1'b0;
        vec_fetch = 2'h0;
        ext_en = 8'hff;
        ext_val = 8'hff;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd(ADDR_LATCH, 8'hff);
        rd(ADDR_DIR, DIR_RST);
        rd(ADDR_OPTION, OPTION_RST);
        rd(ADDR_SENSE, SENSE_RST);
        rd(ADDR_PENDING, 8'h00);
        rd(3'h5, 8'h00);
        chk("pin_pull_en", 8'h40, pin_pull_en);
        // Pin 6 kept high: it is an interrupt input out of reset
        @(posedge clk) ext_val <= 8'he5;
        tick(8);
        rd(ADDR_LATCH, 8'he5);
        wr(ADDR_LATCH, 8'h3c);
        tick(2);
        chk("pin_oe", 8'h00, pin_oe);
        rd(ADDR_LATCH, 8'he5);
        chk("af_in", 8'he5, af_in);
        wr(ADDR_OPTION, 8'h0f);
        @(posedge clk) ext_en <= 8'h00;
        wr(ADDR_DIR, 8'hff);
        tick(2);
        chk("pin_oe", 8'h0f | ~8'h3c, pin_oe);
        chk("pin_out", 8'h3c, pin_out);
        chk("pin_pull_en", 8'h00, pin_pull_en);
        chk("af_in", 8'h3c, af_in);
        rd(ADDR_LATCH, 8'h3c);
        wr(ADDR_DIR, 8'h0f);
        tick(2);
        chk("pin_oe", 8'h0f, pin_oe);
        wr(ADDR_OPTION, 8'h00);
        @(posedge clk) ext_en <= 8'hff;
        ext_val <= 8'hff;
        wr(ADDR_DIR, 8'h00);
        wr(ADDR_OPTION, 8'hf0);
        tick(2);
        chk("pin_pull_en", 8'hf0, pin_pull_en);
        wr(ADDR_OPTION, 8'h00);
        tick(1);
        chk("af_in", 8'hff, af_in);
        @(posedge clk) af_out_en <= 8'h01;
        af_out_val <= 8'h00;
        tick(2);
        chk("pin_oe", 8'h01, pin_oe);
        chk("pin_out", 8'h00, pin_out & 8'h01);
        rd(ADDR_LATCH, 8'hfe);
        @(posedge clk) af_out_val <= 8'h01;
        tick(2);
        chk("pin_oe", 8'h00, pin_oe);
        rd(ADDR_LATCH, 8'hff);
        @(posedge clk) af_out_en <= 8'h00;
        // Pin 0 on vector 0, falling edge, enabled the safe way
        @(posedge clk) int_mask <= 1'b1;
        wr(ADDR_SENSE, 8'h01);
        wr(ADDR_OPTION, 8'h41);
        wr(ADDR_SENSE, 8'h02);
        fetch(2'h3);
        tick(8);
        rd(ADDR_PENDING, 8'h00);
        @(posedge clk) ext_val[0] <= 1'b0;
        tick(8);
        rd(ADDR_PENDING, 8'h01);
        chk("irq_req", 8'h00, 8'(irq_req));
        chk("wake_req", 8'h00, 8'(wake_req));
        @(posedge clk) int_mask <= 1'b0;
        tick(3);
        chk("irq_req", 8'h01, 8'(irq_req));
        chk("wake_req", 8'h01, 8'(wake_req));
        fetch(2'h1);
        tick(2);
        chk("irq_req", 8'h00, 8'(irq_req));
        rd(ADDR_PENDING, 8'h00);
        @(posedge clk) ext_val[0] <= 1'b1;
        tick(8);
        rd(ADDR_PENDING, 8'h00);
        @(posedge clk) ext_val[1] <= 1'b0;
        tick(8);
        wr(ADDR_OPTION, 8'h43);
        tick(4);
        rd(ADDR_PENDING, 8'h01);
        fetch(2'h1);
        // Pin 1 held low hides the edges of pin 0
        @(posedge clk) ext_val[0] <= 1'b0;
        tick(8);
        @(posedge clk) ext_val[0] <= 1'b1;
        tick(8);
        rd(ADDR_PENDING, 8'h00);
        @(posedge clk) ext_val[1] <= 1'b1;
        tick(8);
        @(posedge clk) ext_val[0] <= 1'b0;
        tick(8);
        rd(ADDR_PENDING, 8'h01);
        wr(ADDR_SENSE, 8'h01);
        rd(ADDR_PENDING, 8'h00);
        @(posedge clk) ext_val[0] <= 1'b1;
        tick(8);
        rd(ADDR_PENDING, 8'h01);
        // Pin 0 low while it is disabled the safe way
        fetch(2'h1);
        @(posedge clk) ext_val[0] <= 1'b0;
        tick(8);
        @(posedge clk) int_mask <= 1'b1;
        wr(ADDR_SENSE, 8'h02);
        wr(ADDR_OPTION, 8'h40);
        wr(ADDR_SENSE, 8'h01);
        @(posedge clk) int_mask <= 1'b0;
        tick(8);
        rd(ADDR_PENDING, 8'h00);
        chk("irq_req", 8'h00, 8'(irq_req));
        complete_run();
    end
endmodule // test_gpio_port_with_ext_irq

`default_nettype wire
